/* File: core/gfa_core.sv */
// Notes on behaviour
// - live holdover pin follows loop holdover
// - sticky holdover pin sets on either transition
// - per-pin polarity invert of holdover indications
// - sticky pin held until host clear write
// - alert is OR of enabled sticky bits
// - alert holds until contributors are cleared
// - alert active high, invertible by register
// - disable pin high tristates selected outputs
// - per-pin output mask, registers or boot load
// - clock pin routed unless stage full
// - select pin picks high or low reference
// - rising edge gives one increment pulse
// - rising edge gives one decrement pulse
// - high level disqualifies chosen reference
// - per-pin enable, open-drain or push-pull
// - per-pin pull, up by default
// - live and sticky bit per alarm
// - locked needs loop and analog lock
// - block sticky also holds the alert
// - global enable low blocks new alarms
// - alert enables select contributing bits
// - default mode is readable input
//
// Added by the designer: the address map and register access over AHB-Lite.
`include "gfa_consts.svh"
`default_nettype none
module gfa_core
  import gfa_pkg::*;
(
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins
  input wire logic [`GFA_PINS-1:0] pin_in,
  output logic [`GFA_PINS-1:0] pin_out,
  output logic [`GFA_PINS-1:0] pin_oe,
  output logic [`GFA_PINS-1:0] pin_pull_up,
  output logic [`GFA_PINS-1:0] pin_pull_down,
  // alarm sources
  input wire logic [`GFA_REFS-1:0] ref_alarm,
  input wire logic [`GFA_CHANS-1:0] loop_holdover,
  input wire logic [`GFA_CHANS-1:0] loop_locked,
  input wire logic system_analog_locked,
  // boot configuration
  input wire logic [`GFA_PINS*`GFA_OUTS-1:0] od_map_boot,
  input wire logic [`GFA_PINS-1:0] stage_full,
  // controls toward the timing core
  output logic [`GFA_OUTS-1:0] out_disable,
  output logic [`GFA_PINS-1:0] se_clk_route,
  output logic [`GFA_CHANS-1:0] man_sel_valid,
  output logic [2*`GFA_CHANS-1:0] man_sel_ref,
  output logic [`GFA_CHANS-1:0] osc_inc,
  output logic [`GFA_CHANS-1:0] osc_dec,
  output logic [`GFA_CHANS*`GFA_REFS-1:0] ref_disqualify,
  output logic alert
);

  // sticky update: a set in the same cycle overrides a clear
  function automatic logic [`GFA_ALARMS-1:0] sticky_next(
    input logic [`GFA_ALARMS-1:0] cur,
    input logic [`GFA_ALARMS-1:0] clr,
    input logic [`GFA_ALARMS-1:0] set
  );
    sticky_next = (cur & ~clr) | set;
  endfunction

  logic [1:0] ctrl;
  logic [`GFA_PINS-1:0] gpo;
  logic [`GFA_ALARMS-1:0] alert_en;
  logic [`GFA_PINS*`GFA_OUTS-1:0] od_map;
  logic [`GFA_CFG_W-1:0] cfg_word [`GFA_PINS];
  gfa_pin_cfg_s cfg [`GFA_PINS];
  logic boot_done;
  gfa_aphase_s aph;
  logic [`GFA_PINS-1:0] sync1, sync2, sync3;
  logic [`GFA_PINS-1:0] rise;
  logic [`GFA_ALARMS-1:0] live, live_q, sticky, al_set, al_clr;
  logic [`GFA_BLOCKS-1:0] blk_sticky, blk_set, blk_clr, blk_en;
  logic wr;
  logic [31:0] rd_val;
  logic next_alert;
  logic [`GFA_PINS-1:0] next_out, next_oe, next_drive;
  logic [`GFA_OUTS-1:0] next_od;
  logic [`GFA_PINS-1:0] next_se;
  logic [`GFA_CHANS-1:0] next_msv, next_inc, next_dec;
  logic [2*`GFA_CHANS-1:0] next_msr;
  logic [`GFA_CHANS*`GFA_REFS-1:0] next_disq;

  // unpack configuration words
  always_comb begin
    for (int i = 0; i < `GFA_PINS; i++) begin
      cfg[i] = gfa_pin_cfg_s'(cfg_word[i]);
    end
  end

  // bus address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph <= '0;
    end else if (clk_en && hready) begin
      aph.valid <= hsel && htrans[1];
      aph.write <= hwrite;
      aph.addr <= haddr;
    end
  end

  assign wr = clk_en && aph.valid && aph.write;

  // zero-wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // control, output-value and alert-enable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `GFA_CTRL_RESET;
      gpo <= '0;
      alert_en <= '0;
    end else if (wr) begin
      case (aph.addr)
        `GFA_OFS_CTRL: ctrl <= hwdata[1:0];
        `GFA_OFS_GPO: gpo <= hwdata[`GFA_PINS-1:0];
        `GFA_OFS_ALERT_EN: alert_en <= hwdata[`GFA_ALARMS-1:0];
        default: ;
      endcase
    end
  end

  // output-disable map: boot load once after reset, then registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      od_map <= `GFA_OD_MAP_RESET;
      boot_done <= 1'b0;
    end else if (clk_en) begin
      boot_done <= 1'b1;
      if (!boot_done) begin
        od_map <= od_map_boot;
      end else if (wr && aph.addr == `GFA_OFS_OD_MAP) begin
        od_map <= hwdata;
      end
    end
  end

  // per-pin configuration words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `GFA_PINS; i++) begin
        cfg_word[i] <= `GFA_CFG_RESET;
      end
    end else if (wr && aph.addr >= `GFA_OFS_PIN_CFG &&
                 aph.addr <= `GFA_OFS_PIN_CFG_END) begin
      cfg_word[aph.addr[4:2]] <= hwdata[`GFA_CFG_W-1:0];
    end
  end

  // read data prepared in the address phase
  always_comb begin
    rd_val = '0;
    case (haddr)
      `GFA_OFS_CTRL: rd_val[1:0] = ctrl;
      `GFA_OFS_PIN_IN: rd_val[`GFA_PINS-1:0] = sync2;
      `GFA_OFS_GPO: rd_val[`GFA_PINS-1:0] = gpo;
      `GFA_OFS_LIVE: rd_val[`GFA_ALARMS-1:0] = live;
      `GFA_OFS_STICKY: rd_val[`GFA_ALARMS-1:0] = sticky;
      `GFA_OFS_BLK_STICKY: rd_val[`GFA_BLOCKS-1:0] = blk_sticky;
      `GFA_OFS_ALERT_EN: rd_val[`GFA_ALARMS-1:0] = alert_en;
      `GFA_OFS_OD_MAP: rd_val = od_map;
      default: begin
        if (haddr >= `GFA_OFS_PIN_CFG && haddr <= `GFA_OFS_PIN_CFG_END) begin
          rd_val[`GFA_CFG_W-1:0] = cfg_word[haddr[4:2]];
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (clk_en && hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rd_val;
    end
  end

  // pin input synchroniser and edge stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else if (clk_en) begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign rise = sync2 & ~sync3;

  // live alarm vector
  always_comb begin
    live = '0;
    live[`GFA_AL_REF_LSB +: `GFA_REFS] = ref_alarm;
    live[`GFA_AL_HOLD_LSB +: `GFA_CHANS] = loop_holdover;
    live[`GFA_AL_LOCK_LSB +: `GFA_CHANS] =
      loop_locked & {`GFA_CHANS{system_analog_locked}};
  end

  // set on any change of live state, only while globally enabled
  assign al_set = (live ^ live_q) & {`GFA_ALARMS{ctrl[`GFA_CTRL_GLOBAL_EN]}};
  assign al_clr = (wr && aph.addr == `GFA_OFS_STICKY) ?
                  hwdata[`GFA_ALARMS-1:0] : '0;

  // block-level sets and enables: refs, then loops
  always_comb begin
    for (int b = 0; b < `GFA_REFS; b++) begin
      blk_set[b] = al_set[`GFA_AL_REF_LSB + b];
      blk_en[b] = alert_en[`GFA_AL_REF_LSB + b];
    end
    for (int c = 0; c < `GFA_CHANS; c++) begin
      blk_set[`GFA_REFS + c] = al_set[`GFA_AL_HOLD_LSB + c] |
                               al_set[`GFA_AL_LOCK_LSB + c];
      blk_en[`GFA_REFS + c] = alert_en[`GFA_AL_HOLD_LSB + c] |
                              alert_en[`GFA_AL_LOCK_LSB + c];
    end
  end

  assign blk_clr = (wr && aph.addr == `GFA_OFS_BLK_STICKY) ?
                   hwdata[`GFA_BLOCKS-1:0] : '0;

  // live history and sticky bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      live_q <= '0;
      sticky <= '0;
      blk_sticky <= '0;
    end else if (clk_en) begin
      live_q <= live;
      sticky <= sticky_next(sticky, al_clr, al_set);
      blk_sticky <= (blk_sticky & ~blk_clr) | blk_set;
    end
  end

  // aggregated alert: sticky bits only, never live
  always_comb begin
    next_alert = |(sticky & alert_en) | |(blk_sticky & blk_en);
    next_alert = next_alert ^ ctrl[`GFA_CTRL_ALERT_INV];
  end

  // pin functions
  always_comb begin
    next_out = '0;
    next_oe = '0;
    next_drive = '0;
    next_od = '0;
    next_se = '0;
    next_msv = '0;
    next_msr = '0;
    next_inc = '0;
    next_dec = '0;
    next_disq = '0;
    for (int i = 0; i < `GFA_PINS; i++) begin
      if (cfg[i].enable) begin
        case (cfg[i].mode)
          GFA_GP_OUT: begin
            next_drive[i] = 1'b1;
            next_out[i] = gpo[i];
          end
          GFA_HOLD_LIVE: begin
            next_drive[i] = 1'b1;
            next_out[i] = loop_holdover[cfg[i].chan] ^ cfg[i].invert;
          end
          GFA_HOLD_STICKY: begin
            next_drive[i] = 1'b1;
            next_out[i] = sticky[`GFA_AL_HOLD_LSB + cfg[i].chan] ^
                          cfg[i].invert;
          end
          GFA_ALERT: begin
            next_drive[i] = 1'b1;
            next_out[i] = next_alert;
          end
          GFA_OUT_DIS: begin
            if (sync2[i]) begin
              next_od = next_od | od_map[i*`GFA_OUTS +: `GFA_OUTS];
            end
          end
          GFA_SE_CLK: next_se[i] = !stage_full[i];
          GFA_MAN_SEL: begin
            next_msv[cfg[i].chan] = 1'b1;
            next_msr[2*cfg[i].chan +: 2] =
              sync2[i] ? cfg[i].ref_hi : cfg[i].ref_lo;
          end
          GFA_INC: next_inc[cfg[i].chan] = next_inc[cfg[i].chan] | rise[i];
          GFA_DEC: next_dec[cfg[i].chan] = next_dec[cfg[i].chan] | rise[i];
          GFA_DISQ: begin
            next_disq[cfg[i].chan*`GFA_REFS + cfg[i].ref_hi] =
              next_disq[cfg[i].chan*`GFA_REFS + cfg[i].ref_hi] |
              sync2[i];
          end
          default: ;
        endcase
        // open drain only pulls low; push-pull drives both levels
        if (next_drive[i]) begin
          if (cfg[i].open_drain) begin
            next_oe[i] = !next_out[i];
            next_out[i] = 1'b0;
          end else begin
            next_oe[i] = 1'b1;
          end
        end
      end
    end
  end

  // registered pin and control outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pull_up <= '0;
      pin_pull_down <= '0;
      out_disable <= '0;
      se_clk_route <= '0;
      man_sel_valid <= '0;
      man_sel_ref <= '0;
      osc_inc <= '0;
      osc_dec <= '0;
      ref_disqualify <= '0;
      alert <= 1'b0;
    end else if (clk_en) begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      for (int i = 0; i < `GFA_PINS; i++) begin
        pin_pull_up[i] <= !cfg[i].pull_down;
        pin_pull_down[i] <= cfg[i].pull_down;
      end
      out_disable <= next_od;
      se_clk_route <= next_se;
      man_sel_valid <= next_msv;
      man_sel_ref <= next_msr;
      osc_inc <= next_inc;
      osc_dec <= next_dec;
      ref_disqualify <= next_disq;
      alert <= next_alert;
    end
  end

endmodule
`default_nettype wire

/* File: pkg/gfa_consts.svh */
`ifndef GFA_CONSTS_SVH
`define GFA_CONSTS_SVH
// sizes
`define GFA_PINS 8
`define GFA_CHANS 4
`define GFA_REFS 4
`define GFA_OUTS 4
`define GFA_ALARMS 12
`define GFA_BLOCKS 8
// alarm vector layout
`define GFA_AL_REF_LSB 0
`define GFA_AL_HOLD_LSB 4
`define GFA_AL_LOCK_LSB 8
// register byte offsets
`define GFA_OFS_CTRL 8'h00
`define GFA_OFS_PIN_IN 8'h04
`define GFA_OFS_GPO 8'h08
`define GFA_OFS_LIVE 8'h0c
`define GFA_OFS_STICKY 8'h10
`define GFA_OFS_BLK_STICKY 8'h14
`define GFA_OFS_ALERT_EN 8'h18
`define GFA_OFS_OD_MAP 8'h1c
`define GFA_OFS_PIN_CFG 8'h20
`define GFA_OFS_PIN_CFG_END 8'h3c
// control register fields and reset value
`define GFA_CTRL_GLOBAL_EN 0
`define GFA_CTRL_ALERT_INV 1
`define GFA_CTRL_RESET 2'h1
// pin config register width and reset value (input mode, pull-up)
`define GFA_CFG_W 16
`define GFA_CFG_RESET 16'h0000
`define GFA_OD_MAP_RESET 32'h0000_0000
`endif

/* File: pkg/gfa_pkg.sv */
`default_nettype none
package gfa_pkg;
  // pin function selection
  typedef enum logic [3:0] {
    GFA_GP_IN, GFA_GP_OUT, GFA_HOLD_LIVE, GFA_HOLD_STICKY, GFA_ALERT,
    GFA_OUT_DIS, GFA_SE_CLK, GFA_MAN_SEL, GFA_INC, GFA_DEC, GFA_DISQ
  } gfa_mode_e;
  // per-pin configuration word, high bits first
  typedef struct packed {
    logic [1:0] ref_lo;
    logic [1:0] ref_hi;
    logic [1:0] chan;
    logic invert;
    logic pull_down;
    logic open_drain;
    logic enable;
    logic [1:0] spare;
    gfa_mode_e mode;
  } gfa_pin_cfg_s;
  // captured bus address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } gfa_aphase_s;
endpackage
`default_nettype wire

/* File: verification/gfa_board.sv */
`include "gfa_consts.svh"
`default_nettype none
module gfa_board (
  // pin side of the block
  input wire logic [`GFA_PINS-1:0] pin_out,
  input wire logic [`GFA_PINS-1:0] pin_oe,
  input wire logic [`GFA_PINS-1:0] pin_pull_up,
  input wire logic [`GFA_PINS-1:0] pin_pull_down,
  // phy status lines and board switches
  input wire logic [`GFA_PINS-1:0] ext_oe,
  input wire logic [`GFA_PINS-1:0] ext_val,
  // resolved pin levels
  output logic [`GFA_PINS-1:0] pin_in
);
  // block drive wins, then the far side, then the pull resistor
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val) |
    (~pin_oe & ~ext_oe & (pin_pull_up | ~pin_pull_down));
endmodule
`default_nettype wire

/* File: verification/gfa_core_assertions.sv */
`include "gfa_consts.svh"
`default_nettype none
module gfa_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // causes
  input wire logic [`GFA_PINS-1:0] pin_in,
  input wire logic [`GFA_PINS-1:0] stage_full,
  input wire logic [`GFA_REFS-1:0] ref_alarm,
  input wire logic [`GFA_CHANS-1:0] loop_holdover,
  input wire logic [`GFA_CHANS-1:0] loop_locked,
  input wire logic system_analog_locked,
  // effects
  input wire logic [`GFA_PINS-1:0] pin_oe,
  input wire logic [`GFA_PINS-1:0] pin_pull_up,
  input wire logic [`GFA_PINS-1:0] pin_pull_down,
  input wire logic [`GFA_OUTS-1:0] out_disable,
  input wire logic [`GFA_PINS-1:0] se_clk_route,
  input wire logic [2*`GFA_CHANS-1:0] man_sel_ref,
  input wire logic [`GFA_CHANS-1:0] osc_inc,
  input wire logic [`GFA_CHANS-1:0] osc_dec,
  input wire logic [`GFA_CHANS*`GFA_REFS-1:0] ref_disqualify,
  input wire logic alert
);
  logic [12:0] src;
  logic [12:0] src_q;
  logic [15:0] pins;
  logic [15:0] pins_q;
  logic [2:0] al_q;
  logic [2:0] ct_q;
  logic wr_ev;
  assign src = {ref_alarm, loop_holdover, loop_locked, system_analog_locked};
  assign pins = {pin_in, stage_full};
  assign wr_ev = hsel & hready & htrans[1] & hwrite;
  // cycles since the last write, source change or pin change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_q <= '0;
      pins_q <= '0;
      al_q <= '0;
      ct_q <= '0;
    end else begin
      src_q <= src;
      pins_q <= pins;
      al_q <= (wr_ev || src != src_q) ? 3'h0 : al_q + {2'h0, al_q != 3'h7};
      ct_q <= (wr_ev || pins != pins_q) ? 3'h0 : ct_q + {2'h0, ct_q != 3'h7};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  okay_resp_a: assert property (!hresp)
    else $error("bus response not okay");
  zero_wait_a: assert property ($past(hresetn) |-> hreadyout)
    else $error("wait state inserted");
  pull_one_a: assert property ($past(hresetn) |->
    &(pin_pull_up ^ pin_pull_down)) else $error("pull not exclusive");
  inc_pulse_a: assert property (!(|(osc_inc & $past(osc_inc))))
    else $error("increment pulse too long");
  dec_pulse_a: assert property (!(|(osc_dec & $past(osc_dec))))
    else $error("decrement pulse too long");
  inc_cause_a: assert property (|{osc_inc, osc_dec} |->
    |($past(pin_in, 3) & ~$past(pin_in, 4))) else $error("step without edge");
  alert_cause_a: assert property ($changed(alert) |-> al_q < 3'h6)
    else $error("alert moved without cause");
  ctrl_cause_a: assert property ($changed({out_disable, se_clk_route,
    man_sel_ref, ref_disqualify}) |-> ct_q < 3'h6)
    else $error("control moved without cause");
  drive_cause_a: assert property ($changed(pin_oe) |->
    ct_q < 3'h6 || al_q < 3'h6) else $error("drive moved without cause");
endmodule
bind gfa_core gfa_chk u_chk (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .pin_in, .stage_full, .ref_alarm, .loop_holdover, .loop_locked,
  .system_analog_locked, .pin_oe, .pin_pull_up, .pin_pull_down,
  .out_disable, .se_clk_route, .man_sel_ref, .osc_inc, .osc_dec,
  .ref_disqualify, .alert
);
`default_nettype wire

/* File: verification/gpio_function_alarm_logic_bench.sv */
`default_nettype none
module gpio_function_alarm_logic_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, alert, sys_lk;
  logic [1:0] htrans;
  logic [7:0] haddr, pin_in, pin_out, pin_oe, pu, pd, ext_oe, ext_val;
  logic [7:0] stage_full, se_clk_route, man_sel_ref;
  logic [31:0] hwdata, hrdata, od_map_boot;
  logic [3:0] ref_alarm, hold, lock, out_disable, msv, osc_inc, osc_dec;
  logic [15:0] ref_disqualify;
  int miscompares, n_checks;
  gfa_board u_board (.pin_out, .pin_oe, .pin_pull_up(pu),
    .pin_pull_down(pd), .ext_oe, .ext_val, .pin_in);
  gfa_core u_dut (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .pin_in, .pin_out, .pin_oe, .pin_pull_up(pu), .pin_pull_down(pd),
    .ref_alarm, .loop_holdover(hold), .loop_locked(lock),
    .system_analog_locked(sys_lk), .od_map_boot, .stage_full, .out_disable,
    .se_clk_route, .man_sel_valid(msv), .man_sel_ref, .osc_inc, .osc_dec,
    .ref_disqualify, .alert);
  task automatic close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // one single transfer, address phase then data phase
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk($sformatf("reg %h", a), e, r);
  endtask
  task automatic wt;
    repeat (8) @(posedge hclk);
  endtask
  task automatic clr_all;
    wr(8'h10, 32'hfff);
    wr(8'h14, 32'hff);
    wt();
  endtask
  task automatic t_reset;
    rdc(8'h00, 32'h1);
    rdc(8'h20, 32'h0);
    rdc(8'h1c, 32'h500);
    rdc(8'h04, 32'h5a);
    rdc(8'h40, 32'h0);
    chk("pull_up", 32'hff, pu);
    ext_val <= 8'h00;
  endtask
  task automatic t_hold;
    wr(8'h20, 32'h0042);
    wr(8'h24, 32'h0043);
    clr_all();
    hold <= 4'h1;
    wt();
    chk("hold_in", 32'hf, {pin_oe[1:0], pin_out[1:0]});
    chk("alert", 32'h0, alert);
    hold <= 4'h0;
    wt();
    chk("hold_out", 32'h2, pin_out[1:0]);
    rdc(8'h10, 32'h10);
    clr_all();
    chk("cleared", 32'h0, pin_out[1]);
    wr(8'h24, 32'h0243);
    wt();
    chk("inverted", 32'h1, pin_out[1]);
  endtask
  task automatic t_alert;
    wr(8'h28, 32'h0044);
    wr(8'h18, 32'h100);
    lock <= 4'h1;
    wt();
    chk("lock_only", 32'h0, alert);
    sys_lk <= 1'b1;
    wt();
    chk("alert_on", 32'h1, alert);
    chk("alert_pin", 32'h1, pin_out[2]);
    rdc(8'h0c, 32'h100);
    wr(8'h10, 32'hfff);
    wt();
    chk("block_holds", 32'h1, alert);
    wr(8'h14, 32'hff);
    wt();
    chk("alert_off", 32'h0, alert);
    chk("alert_pin_off", 32'h0, pin_out[2]);
    wr(8'h00, 32'h3);
    wt();
    chk("alert_inv", 32'h1, alert);
    wr(8'h00, 32'h0);
    sys_lk <= 1'b0;
    wt();
    rdc(8'h10, 32'h0);
    wr(8'h00, 32'h1);
    clr_all();
  endtask
  task automatic t_outdis;
    wr(8'h28, 32'h0045);
    ext_val <= 8'h04;
    wt();
    chk("od_boot", 32'h5, out_disable);
    wr(8'h1c, 32'hf00);
    wt();
    chk("od_reg", 32'hf, out_disable);
    ext_val <= 8'h00;
    wt();
    chk("od_low", 32'h0, out_disable);
  endtask
  task automatic t_ctl;
    logic [31:0] ni;
    logic [31:0] nd;
    ni = 0;
    nd = 0;
    wr(8'h2c, 32'h0448);
    wr(8'h30, 32'h0849);
    wr(8'h34, 32'h7847);
    wr(8'h38, 32'h244a);
    wr(8'h3c, 32'h0046);
    ext_val <= 8'hf8;
    repeat (12) begin
      @(posedge hclk);
      ni += osc_inc[1];
      nd += osc_dec[2];
    end
    chk("inc", 32'h1, ni);
    chk("dec", 32'h1, nd);
    chk("sel_hi", 32'h7, {msv[2], man_sel_ref[5:4]});
    chk("disq", 32'h40, ref_disqualify);
    chk("se_clk", 32'h80, se_clk_route);
    stage_full <= 8'h80;
    ext_val <= 8'h00;
    wt();
    chk("sel_lo", 32'h5, {msv[2], man_sel_ref[5:4]});
    chk("no_disq", 32'h0, ref_disqualify);
    chk("se_full", 32'h0, se_clk_route);
  endtask
  task automatic t_drive;
    wr(8'h20, 32'h00c1);
    wr(8'h08, 32'h1);
    wt();
    chk("od_high", 32'h0, pin_oe[0]);
    wr(8'h08, 32'h0);
    wt();
    chk("od_low", 32'h2, {pin_oe[0], pin_out[0]});
    wr(8'h20, 32'h0141);
    wr(8'h08, 32'h1);
    wt();
    chk("pp_high", 32'h3, {pin_oe[0], pin_out[0]});
    chk("pull_dn", 32'h2, {pd[0], pu[0]});
    wr(8'h20, 32'h0001);
    wt();
    chk("disabled", 32'h0, pin_oe[0]);
  endtask
  // clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    close_out();
  end
  initial begin
    {hresetn, hsel, hwrite, sys_lk} = '0;
    {htrans, haddr, hwdata, ref_alarm, hold, lock, stage_full} = '0;
    od_map_boot = 32'h500;
    ext_oe = 8'hff;
    ext_val = 8'h5a;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_hold();
    t_alert();
    t_outdis();
    t_ctl();
    t_drive();
    close_out();
  end
endmodule
`default_nettype wire
